/* File: src/spms_top.sv */
// Purpose: master/slave serial peripheral port with AXI4-Lite registers
// Assumes: pin inputs are synchronous to aclk
// Notes:   serial clock half period is (1 + divider) aclk cycles
//
// Contract
// - shift eight bits out and eight in simultaneously, full duplex.
// - port works only while core clock divider is 0 or 1.
// - chip select, clock, MISO, MOSI use pins zero to three in mode 1.
// - MISO is input as master, driven output as slave.
// - MOSI is driven output as master, input as slave.
// - unit is one byte, MSB first unless LSB-first selected.
// - one byte takes exactly eight serial clock periods.
// - serial clock driven as master, input as slave.
// - master clock equals base clock over twice one plus divider.
// - launch on one clock edge, sample on the other, matching modes.
// - slave exchanges bytes while external chip select is held low.
// - control 16 bits; status, divider, tx, rx 8 bits; status read only.
// - continuous mode keeps going and chip select low while tx valid.
// - single mode sends one byte, next starts after a stall period.
// - control bit 11 loops MOSI back into MISO internally.
// - control bit 10 enables the slave data output driver.
// - control bit 1 picks master when set, slave when clear.
// - control bit 3 sets serial clock idle level.
// - control bit 2 moves clock pulse to start or end of bit.
// - bit 6 starts master on tx write or on rx read.
//
// Register access over AXI4-Lite was chosen for this implementation.
`timescale 1ns/10ps
module spms_top (
  // clock and reset
  input  wire logic        aclk,
  input  wire logic        aresetn,
  // write address channel
  input  wire logic [31:0] awaddr,
  input  wire logic [2:0]  awprot,
  input  wire logic        awvalid,
  output logic             awready,
  // write data channel
  input  wire logic [31:0] wdata,
  input  wire logic [3:0]  wstrb,
  input  wire logic        wvalid,
  output logic             wready,
  // write response channel
  output logic [1:0]       bresp,
  output logic             bvalid,
  input  wire logic        bready,
  // read address channel
  input  wire logic [31:0] araddr,
  input  wire logic [2:0]  arprot,
  input  wire logic        arvalid,
  output logic             arready,
  // read data channel
  output logic [31:0]      rdata,
  output logic [1:0]       rresp,
  output logic             rvalid,
  input  wire logic        rready,
  // general pins zero to three
  input  wire logic [3:0]  pin_in,
  output logic [3:0]       pin_out,
  output logic [3:0]       pin_oe
);

  typedef struct packed {
    logic [15:0]          ctl;
    logic [7:0]           div;
    logic [2:0]           core;
    logic [7:0]           pinmode;
    logic [7:0]           txd;
    logic                 tx_full;
    logic [7:0]           last_tx;
    logic [7:0]           rxd;
    logic                 rx_full;
    logic                 ovf;
    logic                 under;
    logic                 rd_trig;
    spms_pkg::spms_mstate_t ms;
    logic [7:0]           hcnt;
    logic [3:0]           edge_n;
    logic                 sclk;
    logic                 sclk_prev;
    logic                 cs_prev;
    logic                 aw_have;
    logic [31:0]          awaddr;
    logic                 w_have;
    logic [31:0]          wdata;
    logic [3:0]           wstrb;
    logic                 bvalid;
    logic [1:0]           bresp;
    logic                 rvalid;
    logic [1:0]           rresp;
    logic [31:0]          rdata;
    logic                 awready;
    logic                 wready;
    logic                 arready;
    logic [3:0]           pin_out;
    logic [3:0]           pin_oe;
  } spms_state_t;

  spms_state_t q;
  spms_state_t d;

  spms_shift_if sif ();

  spms_shifter u_shifter (
    .aclk    (aclk),
    .aresetn (aresetn),
    .sif     (sif)
  );

  function automatic logic pin_spi(input logic [7:0] pm, input int idx);
    return pm[2*idx +: 2] == spms_pkg::PIN_MODE_SPI;
  endfunction : pin_spi

  function automatic logic mapped(input logic [31:0] a);
    return (a == spms_pkg::ADDR_STATUS) || (a == spms_pkg::ADDR_TX)
        || (a == spms_pkg::ADDR_RX)     || (a == spms_pkg::ADDR_DIV)
        || (a == spms_pkg::ADDR_CTRL)   || (a == spms_pkg::ADDR_CORE)
        || (a == spms_pkg::ADDR_PINMODE);
  endfunction : mapped

  logic       ok;
  logic       master;
  logic       cpol;
  logic       cpha;
  logic       cs_in;
  logic       sclk_in;
  logic       sel;
  logic       evt;
  logic       lead;
  logic       take_tx;
  logic       cont_go;
  logic       ar_fire;
  logic [7:0] next_byte;
  logic [7:0] status;
  logic [15:0] ctl_new;

  assign sif.lsb_first = q.ctl[spms_pkg::CTL_LSB];

  always_comb begin
    d         = q;
    take_tx   = 1'b0;
    evt       = 1'b0;
    lead      = 1'b0;
    ctl_new   = q.ctl;
    sif.load      = 1'b0;
    sif.load_data = 8'h00;
    sif.launch    = 1'b0;
    sif.sample    = 1'b0;

    // gated by core clock setting so a slow core cannot corrupt frames
    ok      = q.ctl[spms_pkg::CTL_EN]
           && (q.core <= spms_pkg::CORE_DIV_MAX);
    master  = q.ctl[spms_pkg::CTL_MASTER];
    cpol    = q.ctl[spms_pkg::CTL_CPOL];
    cpha    = q.ctl[spms_pkg::CTL_CPHA];
    cont_go = q.ctl[spms_pkg::CTL_CONT] && q.tx_full;
    // unmuxed pins read as idle so a foreign pin cannot select us
    cs_in   = pin_spi(q.pinmode, spms_pkg::PIN_CS)
              ? pin_in[spms_pkg::PIN_CS] : 1'b1;
    sclk_in = pin_spi(q.pinmode, spms_pkg::PIN_SCLK)
              ? pin_in[spms_pkg::PIN_SCLK] : cpol;
    sel     = ok && !master && !cs_in;

    next_byte = q.tx_full ? q.txd
              : (q.ctl[spms_pkg::CTL_UNDER] ? q.last_tx : 8'h00);

    // loopback hears our own data line instead of the pin
    if (q.ctl[spms_pkg::CTL_LOOP]) begin
      sif.ser_in = sif.ser_out;
    end else if (master) begin
      sif.ser_in = pin_in[spms_pkg::PIN_MISO];
    end else begin
      sif.ser_in = pin_in[spms_pkg::PIN_MOSI];
    end

    // AXI read: side effects of the read come before any new set
    ar_fire = arvalid && q.arready;
    status  = 8'h00;
    status[spms_pkg::ST_BUSY]   = (q.ms != spms_pkg::M_IDLE) || sel;
    status[spms_pkg::ST_TXFULL] = q.tx_full;
    status[spms_pkg::ST_UNDER]  = q.under;
    status[spms_pkg::ST_RXFULL] = q.rx_full;
    status[spms_pkg::ST_OVF]    = q.ovf;
    if (q.rvalid && rready) begin
      d.rvalid = 1'b0;
    end
    if (ar_fire) begin
      d.rvalid = 1'b1;
      d.rresp  = mapped(araddr) ? spms_pkg::RESP_OKAY
                                : spms_pkg::RESP_DECERR;
      d.rdata  = 32'h00000000;
      if (araddr == spms_pkg::ADDR_STATUS) begin
        d.rdata[7:0] = status;
        d.under      = 1'b0;
      end
      if (araddr == spms_pkg::ADDR_RX) begin
        d.rdata[7:0] = q.rxd;
        d.rx_full    = 1'b0;
        d.ovf        = 1'b0;
        if (!q.ctl[spms_pkg::CTL_TRIG]) begin
          d.rd_trig = 1'b1;
        end
      end
      if (araddr == spms_pkg::ADDR_DIV) begin
        d.rdata[7:0] = q.div;
      end
      if (araddr == spms_pkg::ADDR_CTRL) begin
        d.rdata[15:0] = q.ctl;
      end
      if (araddr == spms_pkg::ADDR_CORE) begin
        d.rdata[2:0] = q.core;
      end
      if (araddr == spms_pkg::ADDR_PINMODE) begin
        d.rdata[7:0] = q.pinmode;
      end
    end

    // master sequencer
    unique case (q.ms)
      spms_pkg::M_IDLE: begin
        d.sclk = cpol;
        d.hcnt = 8'h00;
        if (ok && master && (q.ctl[spms_pkg::CTL_TRIG] ? q.tx_full
                                                       : q.rd_trig)) begin
          take_tx  = 1'b1;
          // a read landing now re-arms instead of being lost
          d.rd_trig = ar_fire && (araddr == spms_pkg::ADDR_RX)
                      && !q.ctl[spms_pkg::CTL_TRIG];
          d.edge_n = 4'h0;
          d.ms     = spms_pkg::M_RUN;
        end
      end
      spms_pkg::M_RUN: begin
        if (q.hcnt == q.div) begin
          d.hcnt   = 8'h00;
          d.sclk   = ~q.sclk;
          evt      = 1'b1;
          lead     = !q.edge_n[0];
          d.edge_n = q.edge_n + 4'h1;
          if ((q.edge_n == spms_pkg::LAST_EDGE) && !cont_go) begin
            d.ms = spms_pkg::M_TAIL;
          end
        end else begin
          d.hcnt = q.hcnt + 8'h01;
        end
      end
      spms_pkg::M_TAIL: begin
        if (q.hcnt == q.div) begin
          d.hcnt = 8'h00;
          d.ms   = spms_pkg::M_STALL;
        end else begin
          d.hcnt = q.hcnt + 8'h01;
        end
      end
      spms_pkg::M_STALL: begin
        // deselect gap before any next single transfer
        if (q.hcnt == q.div) begin
          d.hcnt = 8'h00;
          d.ms   = spms_pkg::M_IDLE;
        end else begin
          d.hcnt = q.hcnt + 8'h01;
        end
      end
    endcase
    if (!ok || !master) begin
      d.ms   = spms_pkg::M_IDLE;
      d.sclk = cpol;
      evt    = 1'b0;
      take_tx = 1'b0;
    end

    // slave edges come from the sampled pin
    d.sclk_prev = sclk_in;
    d.cs_prev   = cs_in;
    if (sel) begin
      evt  = sclk_in != q.sclk_prev;
      lead = q.sclk_prev == cpol;
      if (q.cs_prev) begin
        take_tx = 1'b1;
        evt     = 1'b0;
      end
    end

    // phase picks which edge samples and which launches
    if (evt && (lead ^ cpha)) begin
      sif.sample = 1'b1;
    end
    if (evt && !(lead ^ cpha)) begin
      if (sif.count == spms_pkg::BYTE_BITS) begin
        take_tx = !master || cont_go;
      end else if (!(cpha && (sif.count == 4'h0))) begin
        sif.launch = 1'b1;
      end
    end

    if (take_tx) begin
      sif.load      = 1'b1;
      sif.load_data = next_byte;
      d.tx_full     = 1'b0;
      if (q.tx_full) begin
        d.last_tx = q.txd;
      end else begin
        d.under = 1'b1;
      end
    end

    // receive store: new byte wins over a same-cycle read clear
    if (sif.byte_done) begin
      if (q.rx_full && d.rx_full) begin
        d.ovf = 1'b1;
        if (q.ctl[spms_pkg::CTL_OVWR]) begin
          d.rxd = sif.rx_data;
        end
      end else begin
        d.rxd     = sif.rx_data;
        d.rx_full = 1'b1;
      end
    end

    // AXI write: address and data taken in either order
    if (awvalid && q.awready) begin
      d.aw_have = 1'b1;
      d.awaddr  = awaddr;
    end
    if (wvalid && q.wready) begin
      d.w_have = 1'b1;
      d.wdata  = wdata;
      d.wstrb  = wstrb;
    end
    if (q.bvalid && bready) begin
      d.bvalid = 1'b0;
    end
    if (q.aw_have && q.w_have && !q.bvalid) begin
      d.aw_have = 1'b0;
      d.w_have  = 1'b0;
      d.bvalid  = 1'b1;
      d.bresp   = mapped(q.awaddr) ? spms_pkg::RESP_OKAY
                                   : spms_pkg::RESP_DECERR;
      if (q.awaddr == spms_pkg::ADDR_CTRL) begin
        if (q.wstrb[0]) begin
          ctl_new[7:0] = q.wdata[7:0];
        end
        if (q.wstrb[1]) begin
          ctl_new[15:8] = q.wdata[15:8];
        end
        d.ctl = ctl_new & spms_pkg::CTL_WMASK;
      end
      if (q.wstrb[0]) begin
        if (q.awaddr == spms_pkg::ADDR_DIV) begin
          d.div = q.wdata[7:0];
        end
        if (q.awaddr == spms_pkg::ADDR_TX) begin
          d.txd     = q.wdata[7:0];
          d.tx_full = 1'b1;
        end
        if (q.awaddr == spms_pkg::ADDR_CORE) begin
          d.core = q.wdata[2:0];
        end
        if (q.awaddr == spms_pkg::ADDR_PINMODE) begin
          d.pinmode = q.wdata[7:0];
        end
      end
    end
    d.awready = !d.aw_have && !d.bvalid;
    d.wready  = !d.w_have && !d.bvalid;
    d.arready = !d.rvalid;

    // pin drivers
    d.pin_oe[spms_pkg::PIN_CS] = ok && master
      && pin_spi(q.pinmode, spms_pkg::PIN_CS);
    d.pin_out[spms_pkg::PIN_CS] = !((q.ms == spms_pkg::M_RUN)
                                  || (q.ms == spms_pkg::M_TAIL));
    d.pin_oe[spms_pkg::PIN_SCLK] = ok && master
      && pin_spi(q.pinmode, spms_pkg::PIN_SCLK);
    d.pin_out[spms_pkg::PIN_SCLK] = q.sclk;
    d.pin_oe[spms_pkg::PIN_MISO] = sel && q.ctl[spms_pkg::CTL_SOE]
      && pin_spi(q.pinmode, spms_pkg::PIN_MISO);
    d.pin_out[spms_pkg::PIN_MISO] = sif.ser_out;
    d.pin_oe[spms_pkg::PIN_MOSI] = ok && master
      && pin_spi(q.pinmode, spms_pkg::PIN_MOSI);
    d.pin_out[spms_pkg::PIN_MOSI] = sif.ser_out;
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      q         <= '0;
      q.ctl     <= spms_pkg::CTL_RST;
      q.div     <= spms_pkg::DIV_RST;
      q.core    <= spms_pkg::CORE_RST;
      q.pinmode <= spms_pkg::PINMODE_RST;
      q.ms      <= spms_pkg::M_IDLE;
      q.cs_prev <= 1'b1;
      q.pin_out <= 4'hF;
    end else begin
      q <= d;
    end
  end

  assign awready = q.awready;
  assign wready  = q.wready;
  assign bresp   = q.bresp;
  assign bvalid  = q.bvalid;
  assign arready = q.arready;
  assign rdata   = q.rdata;
  assign rresp   = q.rresp;
  assign rvalid  = q.rvalid;
  assign pin_out = q.pin_out;
  assign pin_oe  = q.pin_oe;

endmodule : spms_top

/* File: shared/spms_pkg.sv */
// Purpose: constants and types shared by the serial port design
// Assumes: register map sits at fixed 32-bit byte addresses
// Notes:   bit positions are int, masks and resets are sized
package spms_pkg;

  // register byte addresses
  localparam logic [31:0] ADDR_STATUS  = 32'hFFFF0A00;
  localparam logic [31:0] ADDR_TX      = 32'hFFFF0A04;
  localparam logic [31:0] ADDR_RX      = 32'hFFFF0A08;
  localparam logic [31:0] ADDR_DIV     = 32'hFFFF0A0C;
  localparam logic [31:0] ADDR_CTRL    = 32'hFFFF0A10;
  localparam logic [31:0] ADDR_CORE    = 32'hFFFF0A14;
  localparam logic [31:0] ADDR_PINMODE = 32'hFFFF0A18;

  // serial_port_control fields
  localparam int CTL_EN     = 0;
  localparam int CTL_MASTER = 1;
  localparam int CTL_CPHA   = 2;
  localparam int CTL_CPOL   = 3;
  localparam int CTL_LSB    = 5;
  localparam int CTL_TRIG   = 6;
  localparam int CTL_UNDER  = 7;
  localparam int CTL_OVWR   = 8;
  localparam int CTL_SSEN   = 9;
  localparam int CTL_SOE    = 10;
  localparam int CTL_LOOP   = 11;
  localparam int CTL_CONT   = 12;
  localparam logic [15:0] CTL_WMASK = 16'h1FEF;

  // serial_port_status fields
  localparam int ST_BUSY   = 0;
  localparam int ST_TXFULL = 1;
  localparam int ST_UNDER  = 2;
  localparam int ST_RXFULL = 3;
  localparam int ST_OVF    = 5;

  // reset values
  localparam logic [15:0] CTL_RST     = 16'h0000;
  localparam logic [7:0]  DIV_RST     = 8'h00;
  localparam logic [2:0]  CORE_RST    = 3'h0;
  localparam logic [7:0]  PINMODE_RST = 8'h00;

  // core clock divider limit and pin muxing
  localparam logic [2:0] CORE_DIV_MAX = 3'h1;
  localparam logic [1:0] PIN_MODE_SPI = 2'h1;
  localparam int PIN_CS   = 0;
  localparam int PIN_SCLK = 1;
  localparam int PIN_MISO = 2;
  localparam int PIN_MOSI = 3;

  // byte framing
  localparam logic [3:0] BYTE_BITS = 4'h8;
  localparam logic [3:0] LAST_EDGE = 4'hF;

  // AXI responses
  localparam logic [1:0] RESP_OKAY   = 2'h0;
  localparam logic [1:0] RESP_DECERR = 2'h3;

  typedef enum logic [1:0] {
    M_IDLE  = 2'b00,
    M_RUN   = 2'b01,
    M_TAIL  = 2'b11,
    M_STALL = 2'b10
  } spms_mstate_t;

endpackage : spms_pkg

/* File: shared/spms_shift_if.sv */
// Purpose: link between the port controller and its shift engine
// Assumes: one clock domain, driven by the controller's aclk
// Notes:   controller owns all strobes, shifter owns the data
`timescale 1ns/10ps
interface spms_shift_if;
  logic       load;
  logic [7:0] load_data;
  logic       launch;
  logic       sample;
  logic       lsb_first;
  logic       ser_in;
  logic       ser_out;
  logic [3:0] count;
  logic       byte_done;
  logic [7:0] rx_data;

  modport ctrl (
    output load, load_data, launch, sample, lsb_first, ser_in,
    input  ser_out, count, byte_done, rx_data
  );
  modport shift (
    input  load, load_data, launch, sample, lsb_first, ser_in,
    output ser_out, count, byte_done, rx_data
  );
endinterface : spms_shift_if

/* File: src/spms_shifter.sv */
// Purpose: eight-bit transmit and receive shift engine
// Assumes: launch and sample never come in the same cycle as load
// Notes:   byte_done pulses one cycle with rx_data already valid
`timescale 1ns/10ps
module spms_shifter (
  // clock and reset
  input wire logic   aclk,
  input wire logic   aresetn,
  // control side
  spms_shift_if.shift sif
);

  typedef struct packed {
    logic [7:0] tx;
    logic [7:0] rx;
    logic [3:0] cnt;
    logic       done;
  } spms_shift_state_t;

  spms_shift_state_t q;
  spms_shift_state_t d;

  always_comb begin
    d      = q;
    d.done = 1'b0;
    if (sif.load) begin
      d.tx  = sif.load_data;
      d.cnt = 4'h0;
    end else begin
      if (sif.launch) begin
        d.tx = sif.lsb_first ? {1'b0, q.tx[7:1]}
                             : {q.tx[6:0], 1'b0};
      end
      // receive runs alongside transmit on the opposite edge
      if (sif.sample && (q.cnt < spms_pkg::BYTE_BITS)) begin
        d.rx   = sif.lsb_first ? {sif.ser_in, q.rx[7:1]}
                               : {q.rx[6:0], sif.ser_in};
        d.cnt  = q.cnt + 4'h1;
        d.done = (q.cnt == spms_pkg::BYTE_BITS - 4'h1);
      end
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      q <= '0;
    end else begin
      q <= d;
    end
  end

  assign sif.ser_out   = sif.lsb_first ? q.tx[0] : q.tx[7];
  assign sif.count     = q.cnt;
  assign sif.byte_done = q.done;
  assign sif.rx_data   = q.rx;

endmodule : spms_shifter

/* File: tb/spms_assertions.sv */
// Purpose: bus and pin checks on the serial port top
// Assumes: divider at least 1, no clock mode change within a frame
// Notes:   bound to every spms_top instance
`timescale 1ns/10ps
module spms_assertions (
  // clock and reset
  input wire logic        aclk,
  input wire logic        aresetn,
  // register bus
  input wire logic        awvalid,
  input wire logic        awready,
  input wire logic        wvalid,
  input wire logic        wready,
  input wire logic        bvalid,
  input wire logic        arvalid,
  input wire logic        arready,
  input wire logic        rvalid,
  input wire logic        rready,
  // pins
  input wire logic [3:0]  pin_out,
  input wire logic [3:0]  pin_oe
);
  logic [7:0] edge_q;
  logic       sclk_q;

  // clock edges seen inside one chip select frame
  always_ff @(posedge aclk) begin
    if (!aresetn || pin_out[0]) edge_q <= 8'h00;
    else if (pin_out[1] != sclk_q) edge_q <= edge_q + 8'h01;
    sclk_q <= pin_out[1];
  end

  default clocking cb @(posedge aclk); endclocking
  default disable iff (!aresetn);

  sequence s_wr_taken;
    awvalid && awready && wvalid && wready;
  endsequence
  sequence s_rd_taken;
    arvalid && arready;
  endsequence

  a_wr_answer: assert property (s_wr_taken |=> ##1 bvalid)
    else $error("write response late");
  a_rd_answer: assert property (s_rd_taken |=> rvalid)
    else $error("read data late");
  a_b_refuse: assert property (bvalid |-> !awready && !wready)
    else $error("write taken while response pending");
  a_ar_refuse: assert property (rvalid |-> !arready)
    else $error("read taken while data pending");
  a_r_release: assert property (rvalid && rready |=> !rvalid)
    else $error("read data not released");
  a_pin_dir: assert property (pin_oe[3] || pin_oe[1] |-> !pin_oe[2])
    else $error("miso driven while clock or mosi driven");
  a_sclk_half: assert property (pin_oe[1] && !pin_out[0]
    && $changed(pin_out[1]) |=> $stable(pin_out[1]))
    else $error("serial clock half period too short");
  a_cs_stall: assert property (pin_oe[0] && $rose(pin_out[0])
    |-> pin_out[0] [*2])
    else $error("chip select stall too short");
  a_byte_edges: assert property (pin_oe[1] && $rose(pin_out[0])
    |-> edge_q != 8'h00 && edge_q[3:0] == 4'h0)
    else $error("frame is not whole bytes of clock edges");
endmodule : spms_assertions

bind spms_top spms_assertions chk (
  .aclk, .aresetn, .awvalid, .awready, .wvalid, .wready, .bvalid,
  .arvalid, .arready, .rvalid, .rready, .pin_out, .pin_oe
);

/* File: tb/spms_slave_model.sv */
// Purpose: external slave on the serial pins, clock mode 0
// Assumes: selected by a low chip select
// Notes:   counts frames and sampling edges for the bench
`timescale 1ns/10ps
module spms_slave_model (
  // pins from the port
  input  wire logic       cs_n,
  input  wire logic       sclk,
  input  wire logic       mosi,
  // byte to send and byte seen
  input  wire logic [7:0] reply,
  output logic            miso = 1'h0,
  output logic [7:0]      got = 8'h00,
  output int              n_rise = 0,
  output int              n_frame = 0
);
  logic [7:0] sh = 8'h00;

  always @(negedge cs_n) begin
    sh = reply;
    miso = reply[7];
    n_rise = 0;
    n_frame++;
  end
  // released line has no pull, so show a wrong level
  always @(posedge cs_n) miso = ~miso;
  always @(posedge sclk) if (!cs_n) begin
    got = {got[6:0], mosi};
    n_rise++;
  end
  always @(negedge sclk) if (!cs_n) begin
    sh = {sh[6:0], 1'h0};
    miso = sh[7];
  end
endmodule : spms_slave_model

/* File: tb/tb_top.sv */
// Purpose: self-checking bench for the serial port top
// Assumes: serial divider 0x0B, far side is a mode 0 slave
// Notes:   pin levels are resolved here from all enables
`timescale 1ns/10ps
module tb_top;
  logic        aclk = 1'h0;
  logic        aresetn = 1'h0;
  logic        awvalid = 1'h0;
  logic        wvalid = 1'h0;
  logic        bready = 1'h0;
  logic        arvalid = 1'h0;
  logic        rready = 1'h0;
  logic        cs_ext = 1'h1;
  logic        sclk_ext = 1'h0;
  logic        mosi_ext = 1'h0;
  logic        awready, wready, bvalid, arready, rvalid, miso;
  logic [31:0] awaddr = 32'h0, wdata = 32'h0, araddr = 32'h0;
  logic [31:0] rdata, v;
  logic [1:0]  bresp, rresp, r;
  logic [3:0]  pin_out, pin_oe, lvl;
  logic [7:0]  reply = 8'h00;
  logic [7:0]  got;
  int          n_rise, n_frame, f0;
  int          miscompares = 0;
  int          n_compared = 0;

  always #20 aclk = ~aclk;
  // undriven pins show the bench's external master and the far slave's miso, idle select high
  assign lvl = (pin_oe & pin_out)
             | (~pin_oe & {mosi_ext, miso, sclk_ext, cs_ext});

  spms_top DUT (
    .aclk, .aresetn, .awaddr, .awprot(3'h0), .awvalid, .awready,
    .wdata, .wstrb(4'hF), .wvalid, .wready, .bresp, .bvalid, .bready,
    .araddr, .arprot(3'h0), .arvalid, .arready, .rdata, .rresp, .rvalid,
    .rready, .pin_in(lvl), .pin_out, .pin_oe
  );
  spms_slave_model FAR (
    .cs_n(lvl[0]), .sclk(lvl[1]), .mosi(lvl[3]), .reply, .miso, .got,
    .n_rise, .n_frame
  );

  task automatic chk(input string n, input logic [31:0] e,
                     input logic [31:0] s);
    n_compared++;
    if (s !== e) begin
      miscompares++;
      $display("unexpected %s expected %h seen %h", n, e, s);
    end
  endtask : chk

  // handshakes judged at the negedge before the deciding edge
  task automatic wr(input logic [31:0] a, input logic [31:0] d);
    logic ta, tw, da, dw, tb;
    da = 1'h0;
    dw = 1'h0;
    tb = 1'h0;
    awaddr <= a;
    wdata <= d;
    awvalid <= 1'h1;
    wvalid <= 1'h1;
    bready <= 1'h1;
    while (!(da && dw)) begin
      @(negedge aclk);
      ta = awvalid && awready;
      tw = wvalid && wready;
      @(posedge aclk);
      if (ta) awvalid <= 1'h0;
      if (tw) wvalid <= 1'h0;
      da |= ta;
      dw |= tw;
    end
    while (!tb) begin
      @(negedge aclk);
      tb = bvalid;
      r = bresp;
      @(posedge aclk);
    end
    bready <= 1'h0;
    @(posedge aclk);
  endtask : wr

  task automatic rd(input logic [31:0] a, output logic [31:0] d);
    logic ta, tr;
    tr = 1'h0;
    araddr <= a;
    arvalid <= 1'h1;
    rready <= 1'h1;
    while (!tr) begin
      @(negedge aclk);
      ta = arvalid && arready;
      tr = rvalid;
      d = rdata;
      r = rresp;
      @(posedge aclk);
      if (ta) arvalid <= 1'h0;
    end
    rready <= 1'h0;
    @(posedge aclk);
  endtask : rd

  task automatic rchk(input string n, input logic [31:0] a,
                      input logic [31:0] e);
    rd(a, v);
    chk(n, e, v);
  endtask : rchk

  task automatic wait_idle;
    repeat (6) @(posedge aclk);
    for (int i = 0; i < 300; i++) begin
      rd(spms_pkg::ADDR_STATUS, v);
      if (v[0] === 1'h0 && v[1] === 1'h0) break;
    end
    repeat (8) @(posedge aclk);
  endtask : wait_idle

  task automatic pins(input string n, input logic [7:0] e,
                      input logic [7:0] m);
    repeat (6) @(posedge aclk);
    @(negedge aclk);
    chk(n, {24'h0, e}, {24'h0, {pin_oe, pin_out} & m});
    @(posedge aclk);
  endtask : pins

  // external mode 0 master, nine aclk cycles per serial period
  task automatic sbyte(input logic [7:0] t, output logic [7:0] s);
    for (int i = 7; i >= 0; i--) begin
      mosi_ext <= t[i];
      repeat (4) @(posedge aclk);
      @(negedge aclk);
      s = {s[6:0], lvl[2]};
      @(posedge aclk);
      sclk_ext <= 1'h1;
      repeat (4) @(posedge aclk);
      sclk_ext <= 1'h0;
    end
  endtask : sbyte

  task automatic xfer(input logic [31:0] c, input logic [7:0] t,
                      input logic [7:0] p, input logic [7:0] eg,
                      input logic [7:0] er);
    reply = p;
    wr(spms_pkg::ADDR_CTRL, c);
    f0 = n_frame;
    wr(spms_pkg::ADDR_TX, {24'h0, t});
    wait_idle;
    chk("frames", f0 + 1, n_frame);
    chk("mosi byte", {24'h0, eg}, {24'h0, got});
    rchk("rx byte", spms_pkg::ADDR_RX, {24'h0, er});
  endtask : xfer

  task automatic pair(input logic [31:0] c);
    wr(spms_pkg::ADDR_CTRL, c);
    f0 = n_frame;
    wr(spms_pkg::ADDR_TX, 32'h11);
    wr(spms_pkg::ADDR_TX, 32'h22);
    wait_idle;
  endtask : pair

  task automatic wrap_up;
    $display("compared %0d miscompares %0d", n_compared, miscompares);
    if (miscompares == 0 && n_compared > 0) $display("Simulation passed");
    else $display("Simulation failed");
    $finish;
  endtask : wrap_up

  initial begin
    repeat (20000) @(posedge aclk);
    miscompares++;
    wrap_up;
  end

  initial begin
    repeat (10) @(posedge aclk);
    aresetn <= 1'h1;
    @(posedge aclk);
    rchk("control", spms_pkg::ADDR_CTRL, 32'h0);
    wr(spms_pkg::ADDR_STATUS, 32'hFF);
    rchk("status", spms_pkg::ADDR_STATUS, 32'h0);
    wr(spms_pkg::ADDR_DIV, 32'hFFFFFFFF);
    rchk("divider", spms_pkg::ADDR_DIV, 32'hFF);
    wr(spms_pkg::ADDR_CTRL, 32'hFFFFFFFF);
    rchk("control", spms_pkg::ADDR_CTRL, 32'h1FEF);
    rd(32'hFFFF0A40, v);
    chk("read resp", 32'h3, {30'h0, r});
    $display("test registers done");
    wr(spms_pkg::ADDR_CTRL, 32'h0);
    wr(spms_pkg::ADDR_DIV, 32'hB);
    wr(spms_pkg::ADDR_PINMODE, 32'h55);
    xfer(32'h43, 8'hA5, 8'h3C, 8'hA5, 8'h3C);
    pins("master oe", 8'hB0, 8'hF0);
    chk("sclk rises", 32'h8, n_rise);
    xfer(32'h63, 8'h01, 8'h35, 8'h80, 8'hAC);
    reply = 8'h69;
    wr(spms_pkg::ADDR_CTRL, 32'h843);
    wr(spms_pkg::ADDR_TX, 32'h96);
    wait_idle;
    rchk("loop rx", spms_pkg::ADDR_RX, 32'h96);
    $display("test master done");
    wr(spms_pkg::ADDR_CTRL, 32'h3);
    f0 = n_frame;
    wr(spms_pkg::ADDR_TX, 32'h5A);
    repeat (60) @(posedge aclk);
    chk("frames", f0, n_frame);
    rd(spms_pkg::ADDR_RX, v);
    wait_idle;
    chk("frames", f0 + 1, n_frame);
    chk("mosi byte", 32'h5A, {24'h0, got});
    $display("test trigger done");
    pair(32'h1043);
    chk("frames", f0 + 1, n_frame);
    chk("mosi byte", 32'h22, {24'h0, got});
    chk("sclk rises", 32'h10, n_rise);
    pair(32'h43);
    chk("frames", f0 + 2, n_frame);
    chk("mosi byte", 32'h22, {24'h0, got});
    $display("test stream done");
    wr(spms_pkg::ADDR_CORE, 32'h2);
    f0 = n_frame;
    wr(spms_pkg::ADDR_TX, 32'h77);
    repeat (80) @(posedge aclk);
    chk("frames", f0, n_frame);
    wr(spms_pkg::ADDR_CORE, 32'h1);
    wait_idle;
    chk("frames", f0 + 1, n_frame);
    chk("mosi byte", 32'h77, {24'h0, got});
    wr(spms_pkg::ADDR_CTRL, 32'h4B);
    pins("sclk idle", 8'h02, 8'h02);
    wr(spms_pkg::ADDR_CTRL, 32'h43);
    pins("sclk idle", 8'h00, 8'h02);
    $display("test clock done");
    rd(spms_pkg::ADDR_RX, v);
    wr(spms_pkg::ADDR_CTRL, 32'h401);
    wr(spms_pkg::ADDR_TX, 32'hC3);
    cs_ext <= 1'h0;
    pins("slave oe", 8'h40, 8'hF0);
    sbyte(8'h6A, v[7:0]);
    chk("miso byte", 32'hC3, {24'h0, v[7:0]});
    rchk("slave rx", spms_pkg::ADDR_RX, 32'h6A);
    wr(spms_pkg::ADDR_CTRL, 32'h1);
    pins("slave oe", 8'h00, 8'hF0);
    cs_ext <= 1'h1;
    $display("test slave done");
    wrap_up;
  end
endmodule : tb_top
